// *** inc/lin_pkg.sv ***
/*
  shared constants, codes and carrier types for the four-channel single-wire
  bus transceiver mode, wake and fault controller.
  assumes a 10 MHz core clock and that the chip operating mode comes from the
  chip's own mode controller as an encoded level.
*/
// How it works
// - power-up off; off always allowed, ignores wake
// - normal mode selectable only in chip normal
// - normal: tx pin drives bus, bus level to rx
// - early dominant suppressed until tx returns high
// - receive-only: driver off; chip normal or stop
// - wake-capable in stop/sleep/restart/normal; forced in fail-safe
// - wake on rising edge after long dominant
// - wake holds rx low until mode changes
// - normal/stop interrupt; others request restart, no interrupt
// - mode reads wake code; no rearm without cause
// - rearm by mode toggle or stop/sleep/fail-safe entry
// - stop/normal wake flagged by interrupt and status
// - stop wake re-enables disabled watchdog if configured
// - sleep wake: restart request, status recorded, no interrupt
// - tx dominant timeout releases bus, sets fault
// - one bit disables tx timeout for all channels
// - bus dominant clamp sets fault, mode unchanged
// - supply undervoltage forces receive-only behaviour
// - slope select latched on chip-select rise, normal only
// - wake filter between 30 and 150 us
package lin_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS      = 100;  // 10 MHz core clock
  localparam int WAKE_FILTER_MIN_US = 30;   // shortest dominant that may wake
  localparam int WAKE_FILTER_MAX_US = 150;  // dominant that must always wake
  // least time: round up to whole cycles
  localparam int WAKE_FILTER_CYC    =
    (WAKE_FILTER_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENABLE_TIME_US     = 10;     // driver settle time, default
  localparam int DOM_TIMEOUT_US     = 12000;  // dominant timeout, default

  // ***************************************************************
  // sizes and reset values
  // ***************************************************************
  localparam int NUM_XCVR           = 4;
  localparam logic LOW_SLOPE_RST    = 1'b0;   // normal slope after reset
  localparam logic RX_IDLE          = 1'b1;   // recessive level on rx pin

  // ***************************************************************
  // transceiver mode codes, two bits each
  // ***************************************************************
  localparam logic [1:0] XM_OFF     = 2'h0;
  localparam logic [1:0] XM_WAKE    = 2'h1;   // the wake-capable code
  localparam logic [1:0] XM_NORMAL  = 2'h2;
  localparam logic [1:0] XM_RXONLY  = 2'h3;
  localparam logic [1:0] XM_RST     = XM_OFF;

  // chip operating modes, driven by the chip mode controller
  typedef enum logic [2:0] {
    CHIP_NORMAL,
    CHIP_STOP,
    CHIP_SLEEP,
    CHIP_RESTART,
    CHIP_FAILSAFE
  } chip_mode_t;

  // per-channel status carried from a channel to the top
  typedef struct packed {
    logic drive_dom;   // bus driver pulls dominant
    logic rx_level;    // level for the receive pin
    logic wake_hit;    // one-cycle wake event
    logic fault_hit;   // one-cycle timeout or clamp event
  } xcvr_stat_t;

endpackage

// *** rtl/lin_ctrl_top.sv ***
/*
  top of the four-channel single-wire bus transceiver controller: mode
  selection against the chip mode, chip-mode rearm, wake reactions,
  fault and wake-source flags, slope selection.
  assumes the chip mode controller supplies the current chip mode and a
  pulse when stop is entered again from stop, and acts on the restart and
  watchdog requests given here; spi decoding lives elsewhere and hands
  over write strobes with their data.
*/
`timescale 1ns/1ps
`default_nettype none
module lin_ctrl_top
  import lin_pkg::*;
#(
  parameter int EN_TIME_US  = ENABLE_TIME_US,
  parameter int TO_TIME_US  = DOM_TIMEOUT_US,
  // settle time as a least time, timeout as a least time, whole cycles
  parameter int EN_CYC      = (EN_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int TO_CYC      = (TO_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire chip_mode_t               chip_mode,
  input  wire logic                     stop_reentry,
  input  wire logic [NUM_XCVR-1:0]      mode_wr,
  input  wire logic [NUM_XCVR-1:0][1:0] mode_wr_data,
  input  wire logic                     cs_rise,
  input  wire logic                     low_slope_wr_data,
  input  wire logic                     tx_timeout_enable,
  input  wire logic                     watchdog_on_bus_wake,
  input  wire logic                     watchdog_active,
  input  wire logic                     xcvr_supply_uv,
  input  wire logic [NUM_XCVR-1:0]      bus_tx_input,
  input  wire logic [NUM_XCVR-1:0]      bus_level,
  input  wire logic [NUM_XCVR-1:0]      fault_clear,
  input  wire logic [NUM_XCVR-1:0]      wake_status_clear,
  input  wire logic                     int_clear,
  output logic [NUM_XCVR-1:0][1:0]      xcvr_mode,
  output logic [NUM_XCVR-1:0]           bus_drive_dom,
  output logic [NUM_XCVR-1:0]           bus_rx_output,
  output logic [NUM_XCVR-1:0]           xcvr_fault_flag,
  output logic [NUM_XCVR-1:0]           wake_source_status,
  output logic                          int_b,
  output logic                          restart_req,
  output logic                          watchdog_enable_req,
  output logic                          low_slope_select
);

  // ***************************************************************
  // synchronised pins
  // ***************************************************************
  logic [NUM_XCVR-1:0] tx_sync;   // transmit pins, 1 = recessive
  logic [NUM_XCVR-1:0] bus_sync;  // bus levels, 1 = recessive
  logic                uv_sync;   // supply undervoltage indication

  pin_sync #(.RST_VAL(1'b0)) u_uv_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_in   (xcvr_supply_uv),
    .pin_out  (uv_sync)
  );

  // ***************************************************************
  // chip mode tracking and rearm
  // ***************************************************************
  chip_mode_t chip_prev_reg, chip_prev_next;  // chip mode last cycle
  logic       rearm;                          // entry into a rearming mode
  logic       failsafe_entry;                 // forces wake-capable

  // entry into stop, sleep or fail-safe, or stop set again from stop
  always_comb begin
    chip_prev_next = chip_mode;
    failsafe_entry = (chip_mode == CHIP_FAILSAFE) && (chip_prev_reg != CHIP_FAILSAFE);
    rearm          = 1'b0;
    if (chip_mode != chip_prev_reg) begin
      case (chip_mode)
        CHIP_STOP:     rearm = 1'b1;
        CHIP_SLEEP:    rearm = 1'b1;
        CHIP_FAILSAFE: rearm = 1'b1;
        default:       rearm = 1'b0;
      endcase
    end else if (chip_mode == CHIP_STOP && stop_reentry) begin
      rearm = 1'b1;  // stop re-entered from stop
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      chip_prev_reg <= CHIP_RESTART;
    end else begin
      chip_prev_reg <= chip_prev_next;
    end
  end

  // ***************************************************************
  // transceiver modes
  // ***************************************************************
  logic [NUM_XCVR-1:0][1:0] mode_reg, mode_next;  // selected modes

  // legality of a requested code in the current chip mode
  function automatic logic mode_allowed(input logic [1:0] code, input chip_mode_t cm);
    logic ok;
    ok = 1'b0;
    case (code)
      XM_OFF:    ok = 1'b1;
      XM_NORMAL: ok = (cm == CHIP_NORMAL);
      XM_RXONLY: ok = (cm == CHIP_NORMAL || cm == CHIP_STOP);
      XM_WAKE:   ok = (cm != CHIP_FAILSAFE);
      default:   ok = 1'b0;
    endcase
    return ok;
  endfunction

  // writes that are not legal in the chip mode leave the mode as it was
  always_comb begin
    mode_next = mode_reg;
    for (int i = 0; i < NUM_XCVR; i++) begin
      if (failsafe_entry) begin
        mode_next[i] = XM_WAKE;  // forced in fail-safe
      end else if (mode_wr[i] && mode_allowed(mode_wr_data[i], chip_mode)) begin
        mode_next[i] = mode_wr_data[i];
      end else if (chip_mode == CHIP_FAILSAFE || chip_mode == CHIP_SLEEP
                   || chip_mode == CHIP_RESTART) begin
        // modes that lost legality with the chip mode drop to off, or to wake-capable in fail-safe
        if (mode_reg[i] == XM_NORMAL || mode_reg[i] == XM_RXONLY) begin
          mode_next[i] = (chip_mode == CHIP_FAILSAFE) ? XM_WAKE : XM_OFF;
        end
      end else if (chip_mode == CHIP_STOP && mode_reg[i] == XM_NORMAL) begin
        mode_next[i] = XM_RXONLY;
      end
      // a wake never changes the code: it keeps reading wake-capable
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_reg <= {NUM_XCVR{XM_RST}};  // off after power-up
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ***************************************************************
  // channels
  // ***************************************************************
  xcvr_stat_t [NUM_XCVR-1:0] stat;  // per-channel drive, rx and events

  for (genvar g = 0; g < NUM_XCVR; g++) begin : g_ch
    pin_sync #(.RST_VAL(1'b1)) u_tx_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pin_in   (bus_tx_input[g]),
      .pin_out  (tx_sync[g])
    );
    pin_sync #(.RST_VAL(1'b1)) u_bus_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pin_in   (bus_level[g]),
      .pin_out  (bus_sync[g])
    );
    xcvr_channel #(
      .EN_CYC (EN_CYC),
      .TO_CYC (TO_CYC),
      .WK_CYC (WAKE_FILTER_CYC)
    ) u_ch (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .mode     (mode_reg[g]),
      .rearm    (rearm),
      .tx_in    (tx_sync[g]),
      .bus_in   (bus_sync[g]),
      .uv       (uv_sync),  // receive-only behaviour while low supply
      .to_en    (tx_timeout_enable),
      .stat     (stat[g])
    );
  end

  // ***************************************************************
  // flags, wake reactions and slope
  // ***************************************************************
  logic [NUM_XCVR-1:0] fault_reg, fault_next;  // sticky fault flags
  logic [NUM_XCVR-1:0] wsrc_reg, wsrc_next;    // sticky wake sources
  logic [NUM_XCVR-1:0] drv_reg, drv_next;      // driver outputs
  logic [NUM_XCVR-1:0] rx_reg, rx_next;        // rx pin outputs
  logic                int_b_reg, int_b_next;  // interrupt, low active
  logic                rst_req_reg, rst_req_next;
  logic                wd_req_reg, wd_req_next;
  logic                slope_reg, slope_next;
  logic                any_wake;

  // set beats clear on every sticky flag so no event is lost
  always_comb begin
    any_wake     = 1'b0;
    fault_next   = fault_reg;
    wsrc_next    = wsrc_reg;
    for (int i = 0; i < NUM_XCVR; i++) begin
      drv_next[i] = stat[i].drive_dom;
      rx_next[i]  = stat[i].rx_level;
      if (stat[i].fault_hit) begin
        fault_next[i] = 1'b1;
      end else if (fault_clear[i]) begin
        fault_next[i] = 1'b0;
      end
      if (stat[i].wake_hit) begin
        wsrc_next[i] = 1'b1;
        any_wake     = 1'b1;
      end else if (wake_status_clear[i]) begin
        wsrc_next[i] = 1'b0;
      end
    end

    int_b_next   = int_b_reg;
    rst_req_next = 1'b0;
    wd_req_next  = 1'b0;
    if (int_clear) begin
      int_b_next = 1'b1;
    end
    if (any_wake) begin
      case (chip_mode)
        CHIP_NORMAL: int_b_next = 1'b0;  // stays in normal
        CHIP_STOP: begin
          int_b_next  = 1'b0;  // stays in stop
          // watchdog back on only if it had been switched off
          wd_req_next = watchdog_on_bus_wake && !watchdog_active;
        end
        default: rst_req_next = 1'b1;  // restart, no interrupt
      endcase
    end

    // slope change only on chip-select rise in chip normal
    slope_next = slope_reg;
    if (cs_rise && chip_mode == CHIP_NORMAL) begin
      slope_next = low_slope_wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fault_reg   <= '0;
      wsrc_reg    <= '0;
      drv_reg     <= '0;
      rx_reg      <= {NUM_XCVR{RX_IDLE}};
      int_b_reg   <= 1'b1;
      rst_req_reg <= 1'b0;
      wd_req_reg  <= 1'b0;
      slope_reg   <= LOW_SLOPE_RST;  // normal slope by default
    end else begin
      fault_reg   <= fault_next;
      wsrc_reg    <= wsrc_next;
      drv_reg     <= drv_next;
      rx_reg      <= rx_next;
      int_b_reg   <= int_b_next;
      rst_req_reg <= rst_req_next;
      wd_req_reg  <= wd_req_next;
      slope_reg   <= slope_next;
    end
  end

  // ***************************************************************
  // outputs, all from flip-flops
  // ***************************************************************
  assign xcvr_mode           = mode_reg;
  assign bus_drive_dom       = drv_reg;
  assign bus_rx_output       = rx_reg;
  assign xcvr_fault_flag     = fault_reg;
  assign wake_source_status  = wsrc_reg;
  assign int_b               = int_b_reg;
  assign restart_req         = rst_req_reg;
  assign watchdog_enable_req = wd_req_reg;
  assign low_slope_select    = slope_reg;

endmodule
`default_nettype wire

// *** rtl/pin_sync.sv ***
/*
  three-flop input synchroniser with agreement filter.
  assumes an input from outside the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      pin_out
);

  // ***************************************************************
  // synchroniser chain
  // ***************************************************************
  logic s1_reg, s2_reg, s3_reg;   // first flop is read by s2 only
  logic out_reg, out_next;        // filtered level

  // a change counts once the second and third stage agree
  always_comb begin
    out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
  end

  // chain and filtered output
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1_reg  <= RST_VAL;
      s2_reg  <= RST_VAL;
      s3_reg  <= RST_VAL;
      out_reg <= RST_VAL;
    end else begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign pin_out = out_reg;

endmodule
`default_nettype wire

// *** rtl/xcvr_channel.sv ***
/*
  one transceiver channel: enable sequence, transmit gating, dominant
  timeout, bus clamp detection, wake filter and rx pin level.
  assumes synchronised tx and bus levels (1 = recessive) and a mode code
  already checked against the chip mode by the top.
*/
`timescale 1ns/1ps
`default_nettype none
module xcvr_channel
  import lin_pkg::*;
#(
  parameter int EN_CYC = 100,
  parameter int TO_CYC = 120000,
  parameter int WK_CYC = 300
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] mode,       // current transceiver mode code
  input  wire logic       rearm,      // chip-mode rearm pulse
  input  wire logic       tx_in,      // synchronised tx pin
  input  wire logic       bus_in,     // synchronised bus level
  input  wire logic       uv,         // supply undervoltage active
  input  wire logic       to_en,      // tx timeout feature on
  output xcvr_stat_t      stat
);

  localparam int CW = $clog2(TO_CYC + 1);
  localparam int EW = $clog2(EN_CYC + 1);
  localparam int WW = $clog2(WK_CYC + 2);

  // ***************************************************************
  // channel state
  // ***************************************************************
  logic [1:0]    mode_prev_reg, mode_prev_next;  // mode of last cycle
  logic [EW-1:0] en_cnt_reg, en_cnt_next;        // enable settle count
  logic          gate_reg, gate_next;            // tx may reach bus
  logic [CW-1:0] to_cnt_reg, to_cnt_next;        // tx dominant length
  logic          to_trip_reg, to_trip_next;      // driver held off
  logic [CW-1:0] cl_cnt_reg, cl_cnt_next;        // bus dominant length
  logic          cl_trip_reg, cl_trip_next;      // clamp already flagged
  logic [WW-1:0] wk_cnt_reg, wk_cnt_next;        // wake dominant length
  logic          armed_reg, armed_next;          // wake detection armed
  logic          held_reg, held_next;            // wake seen, rx held low
  logic          bus_prev_reg;                   // bus level last cycle
  xcvr_stat_t    stat_reg, stat_next;
  logic          mode_chg;

  always_comb begin
    mode_prev_next = mode;
    mode_chg       = (mode != mode_prev_reg);
    en_cnt_next    = en_cnt_reg;
    gate_next      = gate_reg;
    to_cnt_next    = to_cnt_reg;
    to_trip_next   = to_trip_reg;
    cl_cnt_next    = cl_cnt_reg;
    cl_trip_next   = cl_trip_reg;
    wk_cnt_next    = wk_cnt_reg;
    armed_next     = armed_reg;
    held_next      = held_reg;
    stat_next      = '0;

    // enable sequence: restart settle time when normal is entered
    if (mode == XM_NORMAL && mode_chg) begin
      en_cnt_next = EW'(EN_CYC);
      gate_next   = 1'b0;
    end else if (mode != XM_NORMAL) begin
      gate_next   = 1'b0;
    end else if (en_cnt_reg != '0) begin
      en_cnt_next = en_cnt_reg - 1'b1;
    end else if (tx_in) begin
      gate_next   = 1'b1;  // early dominant waits for a high first
    end

    // tx dominant timeout, one enable for all channels
    if (mode == XM_NORMAL && to_en && !tx_in) begin
      if (to_cnt_reg != CW'(TO_CYC)) begin
        to_cnt_next = to_cnt_reg + 1'b1;
      end else if (!to_trip_reg) begin
        to_trip_next        = 1'b1;  // release bus
        stat_next.fault_hit = 1'b1;
      end
    end else begin
      to_cnt_next  = '0;
      to_trip_next = 1'b0;  // driver back once tx is high
    end

    // bus dominant clamp in normal or receive-only; mode left alone
    if ((mode == XM_NORMAL || mode == XM_RXONLY) && !bus_in) begin
      if (cl_cnt_reg != CW'(TO_CYC)) begin
        cl_cnt_next = cl_cnt_reg + 1'b1;
      end else if (!cl_trip_reg) begin
        cl_trip_next        = 1'b1;
        stat_next.fault_hit = 1'b1;
      end
    end else begin
      cl_cnt_next  = '0;
      cl_trip_next = 1'b0;
    end

    // wake filter: count from a falling edge, wake on the rising edge
    if (mode != XM_WAKE) begin
      wk_cnt_next = '0;  // off mode ignores bus activity
    end else if (bus_prev_reg && !bus_in) begin
      wk_cnt_next = WW'(1);  // dominant period begins
    end else if (!bus_in && wk_cnt_reg != '0) begin
      if (wk_cnt_reg != WW'(WK_CYC + 1)) begin
        wk_cnt_next = wk_cnt_reg + 1'b1;
      end
    end else if (bus_in) begin
      // dominant longer than the filter time
      if (wk_cnt_reg == WW'(WK_CYC + 1) && armed_reg) begin
        stat_next.wake_hit = 1'b1;
        held_next          = 1'b1;
        armed_next         = 1'b0;  // no second wake until rearmed
      end
      wk_cnt_next = '0;
    end

    // rearm by toggling the mode or by chip-mode entry
    if (mode_chg) begin
      held_next  = 1'b0;  // rx released on any mode change
      armed_next = 1'b1;
    end else if (rearm) begin
      armed_next = 1'b1;
    end

    // driver: normal mode, settled, no timeout, no undervoltage
    stat_next.drive_dom = (mode == XM_NORMAL) && gate_next && !to_trip_next
                          && !uv && !tx_in;

    // rx pin level by mode
    case (mode)
      XM_NORMAL: stat_next.rx_level = bus_in;
      XM_RXONLY: stat_next.rx_level = bus_in;
      XM_WAKE:   stat_next.rx_level = !held_next;
      default:   stat_next.rx_level = RX_IDLE;
    endcase
  end

  // register all channel state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_prev_reg <= XM_RST;
      en_cnt_reg    <= '0;
      gate_reg      <= 1'b0;
      to_cnt_reg    <= '0;
      to_trip_reg   <= 1'b0;
      cl_cnt_reg    <= '0;
      cl_trip_reg   <= 1'b0;
      wk_cnt_reg    <= '0;
      armed_reg     <= 1'b1;
      held_reg      <= 1'b0;
      bus_prev_reg  <= 1'b1;
      stat_reg      <= '{drive_dom: 1'b0, rx_level: RX_IDLE,
                         wake_hit: 1'b0, fault_hit: 1'b0};
    end else begin
      mode_prev_reg <= mode_prev_next;
      en_cnt_reg    <= en_cnt_next;
      gate_reg      <= gate_next;
      to_cnt_reg    <= to_cnt_next;
      to_trip_reg   <= to_trip_next;
      cl_cnt_reg    <= cl_cnt_next;
      cl_trip_reg   <= cl_trip_next;
      wk_cnt_reg    <= wk_cnt_next;
      armed_reg     <= armed_next;
      held_reg      <= held_next;
      bus_prev_reg  <= bus_in;
      stat_reg      <= stat_next;
    end
  end

  assign stat = stat_reg;

endmodule
`default_nettype wire

// *** verification/lin_bus_node.sv ***
/* far-side bus model: one remote node per channel on an open-drain line.
   assumes the controller drive output is the only other driver. */
`timescale 1ns/1ps
`default_nettype none
module lin_bus_node (
  input  wire logic [3:0] drive_dom,  // controller pulls dominant
  input  wire logic [3:0] node_dom,   // remote node pulls dominant
  output logic      [3:0] bus_level   // 0 = dominant
);
  // wired-and with pull-up: a released line goes recessive, never holds
  assign bus_level = ~(drive_dom | node_dom);
endmodule
`default_nettype wire

// *** verification/lin_ctrl_top_assertions.sv ***
/* port checker for the transceiver controller top.
   assumes bind to lin_ctrl_top; timed wake checks watch channel 0. */
`timescale 1ns/1ps
`default_nettype none
module lin_ctrl_chk
  import lin_pkg::*;
(
  input wire logic                     core_clk,
  input wire logic                     rst_b,
  input wire chip_mode_t               chip_mode,
  input wire logic [NUM_XCVR-1:0]      mode_wr,
  input wire logic [NUM_XCVR-1:0][1:0] mode_wr_data,
  input wire logic                     xcvr_supply_uv,
  input wire logic [NUM_XCVR-1:0][1:0] xcvr_mode,
  input wire logic [NUM_XCVR-1:0]      bus_drive_dom,
  input wire logic [NUM_XCVR-1:0]      bus_rx_output,
  input wire logic [NUM_XCVR-1:0]      wake_source_status,
  input wire logic                     int_b,
  input wire logic                     restart_req
);
  // ************************
  // one clock, sync reset
  // ************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_reset_mode_off: assert property ($rose(rst_b) |-> xcvr_mode == '0 && int_b)
    else $error("not off after reset");
  chk_normal_refused: assert property (mode_wr[0] && mode_wr_data[0] == XM_NORMAL
    && chip_mode != CHIP_NORMAL |=> xcvr_mode[0] != XM_NORMAL) else $error("normal taken");
  chk_normal_taken: assert property (mode_wr[0] && mode_wr_data[0] == XM_NORMAL
    && chip_mode == CHIP_NORMAL |=> xcvr_mode[0] == XM_NORMAL) else $error("normal lost");
  chk_uv_no_drive: assert property (xcvr_supply_uv [*8] |-> bus_drive_dom == '0)
    else $error("drive in undervoltage");
  chk_failsafe_wake: assert property (chip_mode == CHIP_FAILSAFE
    && $past(chip_mode) != CHIP_FAILSAFE |=> xcvr_mode == {4{XM_WAKE}})
    else $error("fail-safe not wake");
  chk_wake_rx_held: assert property ($rose(wake_source_status[0]) && !mode_wr[0]
    |-> ##[0:3] !bus_rx_output[0] [*4]) else $error("rx not held low");
  chk_wake_int_low: assert property ($rose(wake_source_status[0]) && (chip_mode ==
    CHIP_NORMAL || chip_mode == CHIP_STOP) |-> ##[0:2] !int_b) else $error("no interrupt");
  chk_restart_no_int: assert property (restart_req |-> int_b && chip_mode != CHIP_NORMAL
    && chip_mode != CHIP_STOP) else $error("bad restart");
  cover property ($rose(wake_source_status[0]));
  cover property (restart_req);
  cover property (xcvr_supply_uv [*8]);
endmodule
bind lin_ctrl_top lin_ctrl_chk lin_ctrl_chk_i (.core_clk, .rst_b, .chip_mode, .mode_wr,
  .mode_wr_data, .xcvr_supply_uv, .xcvr_mode, .bus_drive_dom, .bus_rx_output,
  .wake_source_status, .int_b, .restart_req);
`default_nettype wire

// *** verification/lin_ctrl_top_test.sv ***
/* self-checking bench: controller plus remote bus nodes.
   assumes shortened counts (settle 4, timeout 20 cycles). */
`timescale 1ns/1ps
`default_nettype none
module lin_ctrl_top_test;
  import lin_pkg::*;
  logic            core_clk = 0, rst_b = 0, cs_rise = 0, slope_d = 0, uv = 0, clr = 0, b;
  chip_mode_t      chip_mode = CHIP_STOP;
  logic [3:0]      mode_wr = '0, tx = '1, node_dom = '0, bus, drv, rx, flt, wsrc;
  logic [3:0][1:0] wdata = '0, xcvr_mode;
  logic            int_b, restart_req, slope, wdr, toen = 1;
  logic [7:0]      q[$], seen = '0, np = '0;  // notes of expected flag rises
  logic [31:0]     lfsr = 32'h93f76bd7;
  int              num_errors = 0, n_checks = 0;
  always #50 core_clk = ~core_clk;
  lin_ctrl_top #(.EN_CYC(4), .TO_CYC(20)) lin_ctrl_top_i (.core_clk, .rst_b, .chip_mode,
    .stop_reentry(1'b0), .mode_wr, .mode_wr_data(wdata), .cs_rise, .low_slope_wr_data(slope_d),
    .tx_timeout_enable(toen), .watchdog_on_bus_wake(1'b1), .watchdog_active(1'b0),
    .xcvr_supply_uv(uv), .bus_tx_input(tx), .bus_level(bus), .fault_clear({4{clr}}),
    .wake_status_clear({4{clr}}), .int_clear(clr), .xcvr_mode, .bus_drive_dom(drv),
    .bus_rx_output(rx), .xcvr_fault_flag(flt), .wake_source_status(wsrc), .int_b,
    .restart_req, .watchdog_enable_req(wdr), .low_slope_select(slope));
  lin_bus_node lin_bus_node_i (.drive_dom(drv), .node_dom, .bus_level(bus));
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) num_errors++;
    if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0 && q.size() == 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // mode write on channel 0, result compared two edges later
  task automatic wr(input logic [1:0] code, exp);
    mode_wr[0] <= 1'b1;
    wdata[0] <= code;
    cyc(1);
    mode_wr[0] <= 1'b0;
    cyc(2);
    chk(xcvr_mode[0], exp);
  endtask
  // remote node holds the bus dominant for n cycles
  task automatic pulse(input int ch, n, input logic [7:0] note);
    if (note != 0) q.push_back(note);
    node_dom[ch] <= 1'b1;
    cyc(n);
    node_dom[ch] <= 1'b0;
    cyc(12);
  endtask
  // any new flag rise takes the oldest note; none expected means stray
  always @(posedge core_clk) begin
    seen <= {flt, wsrc};
    np <= np + {6'h0, wdr, restart_req};  // watchdog pulses count 2, restarts 1
    if (rst_b && ({flt, wsrc} & ~seen) != 0)
      chk({flt, wsrc} & ~seen, (q.size() > 0) ? q.pop_front() : 8'h00);
  end
  initial begin
    cyc(6);
    rst_b <= 1'b1;
    cyc(4);
    chk(xcvr_mode, 8'h00);
    wr(XM_NORMAL, XM_OFF);
    wr(XM_RXONLY, XM_RXONLY);
    wr(XM_WAKE, XM_WAKE);
    pulse(1, 400, 8'h00);
    pulse(0, 250, 8'h00);
    pulse(0, 320, 8'h01);
    chk({int_b, rx[0]}, 8'h00);
    pulse(0, 320, 8'h00);
    chk(np, 8'h02);
    $display("stop wake test done");
    clr <= 1'b1;
    chip_mode <= CHIP_SLEEP;
    cyc(1);
    clr <= 1'b0;
    pulse(0, 320, 8'h01);
    chk(int_b, 1'b1);
    chk(np, 8'h03);
    $display("sleep wake test done");
    chip_mode <= CHIP_NORMAL;
    tx[0] <= 1'b0;
    wr(XM_NORMAL, XM_NORMAL);
    cyc(8);
    chk(drv[0], 1'b0);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      b = lfsr[0] | ~i[0];
      tx[0] <= b;
      cyc(14);
      chk({drv[0], rx[0]}, {~b, b});
    end
    tx[0] <= 1'b0;
    q.push_back(8'h10);
    cyc(32);
    chk(drv[0], 1'b0);
    tx[0] <= 1'b1;
    cyc(6);
    tx[0] <= 1'b0;
    cyc(8);
    chk(drv[0], 1'b1);
    uv <= 1'b1;
    cyc(10);
    chk(drv[0], 1'b0);
    uv <= 1'b0;
    tx[0] <= 1'b1;
    slope_d <= 1'b1;
    cs_rise <= 1'b1;
    cyc(1);
    cs_rise <= 1'b0;
    cyc(1);
    chk(slope, 1'b1);
    toen <= 1'b0;
    tx[0] <= 1'b0;
    cyc(32);
    chk(drv[0], 1'b1);
    tx[0] <= 1'b1;
    $display("normal mode test done");
    chip_mode <= CHIP_FAILSAFE;
    cyc(3);
    chk(xcvr_mode, 8'h55);
    complete_run();
  end
endmodule
`default_nettype wire
